// ==== rtl/gdcj_pkg.sv ====
// shared constants for the gapped ds3 link: register map, burst schedule,
// link slot timing.
// assumes a 25 MHz system clock and one link channel per end pair.
//
// How it works
// - low select set, high clear: narrow loop
// - path bit one means transmit, zero receive
// - recovery-off bit clear keeps fast switch recovery
// - only host mode may disable fast recovery
// - eight-bit control, three upper bits read zero
// - any gap length accepted, no timeout
// - mapper side regularises gapped clock and data
// - seven pulses then one empty slot
// - one pulse or gap per reference period; here one per 160 ns link slot of SLOT_CLKS clk_i
// - five pulses then one empty slot
// - first frame: 63 sevens, 36 fives
// - first frame is 621 pulses, 720 slots
// - six pulses, no empty slot
// - second frame: 63 sevens, 35 fives, one six
// - two first frames, one second, repeat
package gdcj_pkg;

  // register map, one control register per channel
  localparam int NUM_CH = 3;
  localparam logic [7:0] OFF_ATT_CTRL_CH0 = 8'h07;
  localparam logic [7:0] OFF_ATT_CTRL_CH1 = 8'h0F;
  localparam logic [7:0] OFF_ATT_CTRL_CH2 = 8'h17;
  localparam logic [7:0] ATT_CTRL_RESET = 8'h00;
  localparam logic [7:0] ATT_CTRL_RW_MASK = 8'h1F;
  localparam int BIT_BW_LOW = 0;
  localparam int BIT_PATH_TX = 1;
  localparam int BIT_BW_HIGH = 2;
  localparam int BIT_FIFO_CLEAR = 3;
  localparam int BIT_RECOVERY_OFF = 4;

  // schedule of the gapped clock
  localparam int MAX_GAP_SLOTS = 59;
  localparam logic [2:0] SEVEN_PULSES = 3'h7;
  localparam logic [2:0] FIVE_PULSES = 3'h5;
  localparam logic [2:0] SIX_PULSES = 3'h6;
  localparam logic [3:0] SEVEN_SLOTS = 4'h8;
  localparam logic [3:0] FIVE_SLOTS = 4'h6;
  localparam logic [3:0] SIX_SLOTS = 4'h6;
  localparam logic [6:0] SEVEN_REPS = 7'h3F;
  localparam logic [6:0] FIVE_REPS_A = 7'h24;
  localparam logic [6:0] FIVE_REPS_B = 7'h23;
  localparam logic [6:0] SIX_REPS = 7'h01;
  localparam logic [1:0] FRAMES_PER_SUPER = 2'h3;
  localparam logic [1:0] FRAME_B_INDEX = 2'h2;
  localparam logic [9:0] FRAME_A_PULSES = 10'h26D;
  localparam logic [9:0] FRAME_B_PULSES = 10'h26E;
  localparam logic [9:0] FRAME_SLOTS = 10'h2D0;

  // timing: reference rate of the schedule, and the link slot in clk_i
  localparam int REF_FREQ_KHZ = 51840;
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int LINK_PERIOD_NS = 160;
  localparam int CLK_PERIOD_NS = 1000000 / CLK_FREQ_KHZ;
  localparam int SLOT_CLKS = LINK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum {SEG_SEVEN, SEG_FIVE, SEG_SIX} gdcj_seg_e;

endpackage

// ==== rtl/gdcj_link_if.sv ====
// gapped ds3 clock and data between the mapper side and the line channel.
// assumes the mapper side drives both wires; the clock rests low in gaps.
`timescale 1ns/1ps
`default_nettype none
interface gdcj_link_if;
  logic tclk;
  logic tdata;
  modport mapper (output tclk, output tdata);
  modport line (input tclk, input tdata);
endinterface
`default_nettype wire

// ==== rtl/gdcj_fifo.sv ====
// small valid/ready buffer held in flip-flops.
// assumes one clock; ready and valid are registered.
`timescale 1ns/1ps
`default_nettype none
module gdcj_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("gdcj_fifo: bad geometry");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  logic [AW:0] count_nxt;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem_r[rd_ptr_r];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      count_r <= count_nxt;
      // flags kept as flops so the ports come straight from registers
      in_ready_o <= (count_nxt != FULL_CNT);
      out_valid_o <= (count_nxt != '0);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/gdcj_line_channel.sv ====
// line channel end: attenuator control registers and gapped data capture.
// assumes link.tclk is a gapped clock from the mapper side, idle low at reset,
// and that its edges are at least two clk_i periods apart.
`timescale 1ns/1ps
`default_nettype none
module gdcj_line_channel
  import gdcj_pkg::*;
#(
  parameter int LINK_CH = 0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  gdcj_link_if.line link,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic host_mode_i,
  input wire logic hw_bw_low_i,
  input wire logic hw_bw_high_i,
  input wire logic hw_path_tx_i,
  output logic narrow_bw_o,
  output logic path_tx_o,
  output logic fast_recovery_o,
  output logic fifo_clear_o,
  output logic rx_bit_o,
  output logic rx_valid_o
);
  initial begin
    if (LINK_CH < 0 || LINK_CH >= NUM_CH) $error("gdcj_line_channel: LINK_CH");
  end

  // index of a control register, NUM_CH when unmapped
  function automatic int reg_index(input logic [7:0] a);
    case (a)
      OFF_ATT_CTRL_CH0: reg_index = 0;
      OFF_ATT_CTRL_CH1: reg_index = 1;
      OFF_ATT_CTRL_CH2: reg_index = 2;
      default: reg_index = NUM_CH;
    endcase
  endfunction

  logic [7:0] ctrl_r [NUM_CH];
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic host_mode_r;
  logic [7:0] sel;
  logic bw_low;
  logic bw_high;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ctrl
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_r[g] <= ATT_CTRL_RESET;
        end else if (reg_wr_i && reg_index(reg_addr_i) == g) begin
          ctrl_r[g] <= reg_wdata_i & ATT_CTRL_RW_MASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i && reg_index(reg_addr_i) < NUM_CH) begin
      reg_rdata_o <= ctrl_r[reg_index(reg_addr_i)];
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // straps and hardware-mode pins come from outside, so two flops first
  always_ff @(posedge clk_i) begin
    pin_meta_r <= {hw_path_tx_i, hw_bw_high_i, hw_bw_low_i, host_mode_i};
    pin_sync_r <= pin_meta_r;
  end

  // mode strap caught while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) host_mode_r <= pin_sync_r[0];
  end

  assign sel = ctrl_r[LINK_CH];
  assign bw_low = host_mode_r ? sel[BIT_BW_LOW] : pin_sync_r[1];
  assign bw_high = host_mode_r ? sel[BIT_BW_HIGH] : pin_sync_r[2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      narrow_bw_o <= 1'b0;
      path_tx_o <= 1'b0;
      fast_recovery_o <= 1'b1;
      fifo_clear_o <= 1'b0;
    end else begin
      narrow_bw_o <= bw_low && !bw_high;
      path_tx_o <= host_mode_r ? sel[BIT_PATH_TX] : pin_sync_r[3];
      // pin control has no way to turn fast recovery off
      fast_recovery_o <= !(host_mode_r && sel[BIT_RECOVERY_OFF]);
      fifo_clear_o <= host_mode_r && sel[BIT_FIFO_CLEAR];
    end
  end

  // link domain: one bit per gapped edge; power-up value since the link
  // clock gives no edges during reset
  logic cap_bit_r = 1'b0;
  logic cap_tog_r = 1'b0;
  always_ff @(posedge link.tclk) begin
    cap_bit_r <= link.tdata;
    cap_tog_r <= ~cap_tog_r;
  end

  // toggle crossing; cap_bit_r holds a full link period, longer than the sync
  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_seen_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_seen_r <= 1'b0;
      rx_bit_o <= 1'b0;
      rx_valid_o <= 1'b0;
    end else begin
      tog_meta_r <= cap_tog_r;
      tog_sync_r <= tog_meta_r;
      tog_seen_r <= tog_sync_r;
      // no gap timeout: a long silence is simply no data
      rx_valid_o <= (tog_sync_r != tog_seen_r) && !fifo_clear_o;
      if (tog_sync_r != tog_seen_r) rx_bit_o <= cap_bit_r;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/gdcj_mapper_shaper.sv ====
// mapper-side shaper: buffers gapped ds3 bits and replays them on the
// regular burst schedule as a gapped clock with data.
// assumes in_* comes from logic on clk_i; link clock is made here by a divider.
`timescale 1ns/1ps
`default_nettype none
module gdcj_mapper_shaper
  import gdcj_pkg::*;
#(
  parameter int SLOT_DIV = SLOT_CLKS,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  gdcj_link_if.mapper link,
  input wire logic in_valid_i,
  input wire logic in_bit_i,
  output logic in_ready_o,
  output logic stall_o,
  output logic super_start_o,
  output logic [1:0] frame_idx_o,
  output logic [9:0] frame_pulses_o
);
  localparam int PW = $clog2(SLOT_DIV);
  localparam logic [PW-1:0] PH_LAST = PW'(SLOT_DIV - 1);
  localparam logic [PW-1:0] PH_RISE = PW'(SLOT_DIV / 2 - 1);
  localparam logic [PW-1:0] PH_FALL = PW'(SLOT_DIV - 2);

  initial begin
    if (SLOT_DIV < 4 || (SLOT_DIV % 2) != 0) begin
      $error("gdcj_mapper_shaper: SLOT_DIV must be even and at least 4");
    end
    if (BUF_DEPTH < 2) $error("gdcj_mapper_shaper: BUF_DEPTH below 2");
  end

  // pulses at the head of a burst of the given kind
  function automatic logic [2:0] seg_pulses(input gdcj_seg_e s);
    case (s)
      SEG_SEVEN: seg_pulses = SEVEN_PULSES;
      SEG_FIVE: seg_pulses = FIVE_PULSES;
      SEG_SIX: seg_pulses = SIX_PULSES;
      default: seg_pulses = SIX_PULSES;
    endcase
  endfunction

  // slots a burst occupies, its empty slot included
  function automatic logic [3:0] seg_slots(input gdcj_seg_e s);
    case (s)
      SEG_SEVEN: seg_slots = SEVEN_SLOTS;
      SEG_FIVE: seg_slots = FIVE_SLOTS;
      SEG_SIX: seg_slots = SIX_SLOTS;
      default: seg_slots = SIX_SLOTS;
    endcase
  endfunction

  // repeats of a burst within the current frame
  function automatic logic [6:0] seg_reps(input gdcj_seg_e s,
                                          input logic frame_b);
    case (s)
      SEG_SEVEN: seg_reps = SEVEN_REPS;
      SEG_FIVE: seg_reps = frame_b ? FIVE_REPS_B : FIVE_REPS_A;
      SEG_SIX: seg_reps = SIX_REPS;
      default: seg_reps = SIX_REPS;
    endcase
  endfunction

  // buffer between the bursty source and the schedule
  logic buf_valid;
  logic buf_bit;
  logic buf_pop;

  gdcj_fifo #(
    .WIDTH(1),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(in_valid_i),
    .in_data_i(in_bit_i),
    .in_ready_o(in_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_bit),
    .out_ready_i(buf_pop)
  );

  // schedule position
  logic [PW-1:0] phase_r;
  gdcj_seg_e seg_r;
  logic [3:0] slot_r;
  logic [6:0] rep_r;
  logic [1:0] frame_r;
  logic pulse_r;
  logic tclk_r;
  logic tdata_r;

  logic slot_start;
  logic frame_b;
  logic is_pulse;
  logic advance;
  logic last_slot;
  logic last_rep;
  logic last_seg;

  assign slot_start = (phase_r == PH_LAST);
  assign frame_b = (frame_r == FRAME_B_INDEX);
  assign is_pulse = ({1'b0, seg_pulses(seg_r)} > slot_r);
  // a pulse slot with nothing buffered waits in place
  assign buf_pop = slot_start && is_pulse && buf_valid;
  assign advance = slot_start && (!is_pulse || buf_valid);
  assign last_slot = (slot_r == seg_slots(seg_r) - 4'h1);
  assign last_rep = (rep_r == seg_reps(seg_r, frame_b) - 7'h01);
  assign last_seg = (seg_r == SEG_SIX) || (seg_r == SEG_FIVE && !frame_b);

  // divider making the slot rate of the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= '0;
    end else if (slot_start) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + PW'(1);
    end
  end

  // one pulse or gap per slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
      tdata_r <= 1'b0;
      stall_o <= 1'b0;
    end else if (slot_start) begin
      pulse_r <= is_pulse && buf_valid;
      stall_o <= is_pulse && !buf_valid;
      // data only moves with a pulse; gaps hold the last bit
      if (buf_pop) tdata_r <= buf_bit;
    end
  end

  // clock high in the back half of a pulse slot, after data has settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tclk_r <= 1'b0;
    end else begin
      tclk_r <= pulse_r && (phase_r >= PH_RISE) && (phase_r <= PH_FALL);
    end
  end

  assign link.tclk = tclk_r;
  assign link.tdata = tdata_r;

  // burst, repeat, frame walk
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_r <= '0;
      rep_r <= '0;
      seg_r <= SEG_SEVEN;
      frame_r <= '0;
    end else if (advance) begin
      if (!last_slot) begin
        slot_r <= slot_r + 4'h1;
      end else begin
        slot_r <= '0;
        if (!last_rep) begin
          rep_r <= rep_r + 7'h01;
        end else begin
          rep_r <= '0;
          case (seg_r)
            SEG_SEVEN: seg_r <= SEG_FIVE;
            SEG_FIVE: seg_r <= frame_b ? SEG_SIX : SEG_SEVEN;
            SEG_SIX: seg_r <= SEG_SEVEN;
            default: seg_r <= SEG_SEVEN;
          endcase
          if (last_seg) begin
            // two first frames then one second frame
            frame_r <= (frame_r == FRAMES_PER_SUPER - 2'h1) ? 2'h0
                                                           : frame_r + 2'h1;
          end
        end
      end
    end
  end

  // progress report: frame index and pulses sent in it so far
  logic frame_end;
  logic frame_end_r;
  assign frame_end = advance && last_slot && last_rep && last_seg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_pulses_o <= '0;
      frame_idx_o <= '0;
      super_start_o <= 1'b0;
      frame_end_r <= 1'b0;
    end else begin
      frame_idx_o <= frame_r;
      frame_end_r <= frame_end;
      // pulses per frame come out at 621 or 622
      // cleared a cycle late: a frame may end on a pulse slot
      if (frame_end_r) begin
        frame_pulses_o <= '0;
      end else if (buf_pop) begin
        frame_pulses_o <= frame_pulses_o + 10'h001;
      end
      super_start_o <= frame_end && frame_b;
    end
  end
endmodule
`default_nettype wire

// ==== tb/gdcj_assertions.sv ====
// checker on the gapped link wires between the two ends.
// assumes clk_i samples tclk with four clocks to a slot.
`timescale 1ns/1ps
`default_nettype none
module gdcj_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tclk,
  input wire logic tdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tclk_q_r;
  logic [1:0] ph_r;
  logic [1:0] rise_ph_r;
  logic seen_r;
  logic [3:0] gap_r;
  logic [4:0] run_r;
  logic rise;
  assign rise = tclk & ~tclk_q_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tclk_q_r <= 1'b0;
      ph_r <= 2'h0;
    end else begin
      tclk_q_r <= tclk;
      ph_r <= ph_r + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
      rise_ph_r <= 2'h0;
    end else if (rise && !seen_r) begin
      seen_r <= 1'b1;
      rise_ph_r <= ph_r;
    end
  end
  // run of back-to-back pulses; six then seven merge across frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r <= 4'h0;
      run_r <= 5'h00;
    end else if (rise) begin
      gap_r <= 4'h0;
      run_r <= (gap_r == 4'h3) ? run_r + 5'h01 : 5'h01;
    end else if (gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end
  tclk_high_len_a: assert property ($rose(tclk) |-> tclk[*2] ##1 !tclk)
    else $error("tclk high time wrong");
  tclk_low_len_a: assert property ($fell(tclk) |-> !tclk[*2])
    else $error("tclk low time too short");
  data_setup_a: assert property ($rose(tclk) |-> $stable(tdata))
    else $error("tdata moved at rising tclk");
  data_hold_a: assert property ($rose(tclk) |=> $stable(tdata))
    else $error("tdata moved while tclk high");
  rise_spacing_a: assert property ($rose(tclk) |=> (!$rose(tclk))[*3])
    else $error("tclk rises closer than one slot");
  slot_grid_a: assert property (rise && seen_r |-> ph_r == rise_ph_r)
    else $error("tclk rise off the slot grid");
  burst_len_a: assert property (run_r <= 5'h0D)
    else $error("pulse run too long");
  idle_after_reset_a: assert property ($fell(rst_i) |-> !tclk[*2])
    else $error("tclk pulsed right after reset");
  cover property (run_r == 5'h07);
  cover property (run_r == 5'h0D);
  cover property ($fell(tclk) ##1 !tclk[*5]);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// bench: shaper end feeding the line channel end over the link.
// assumes both ends share clk_i; registers live on the line channel.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gdcj_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] outs;
  } gdcj_row_s;
  // outs: narrow, path tx, fast recovery
  gdcj_row_s rows [8] = '{
    '{8'h07, 8'h03, 8'h03, 3'h7}, '{8'h07, 8'h05, 8'h05, 3'h1},
    '{8'h07, 8'hFF, 8'h1F, 3'h2}, '{8'h07, 8'h11, 8'h11, 3'h4},
    '{8'h0F, 8'hE2, 8'h02, 3'h4}, '{8'h17, 8'h1F, 8'h1F, 3'h4},
    '{8'h08, 8'hFF, 8'h00, 3'h4}, '{8'h07, 8'h00, 8'h00, 3'h1}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic host = 1'b1;
  logic hw_low = 1'b0;
  logic hw_high = 1'b0;
  logic hw_path = 1'b0;
  logic in_valid = 1'b0;
  logic in_bit = 1'b0;
  logic feed = 1'b0;
  logic refused = 1'b0;
  logic tq = 1'b0;
  logic [1:0] idx_q = 2'h0;
  logic [1:0] idx_qq = 2'h0;
  logic [9:0] fpulses;
  logic [9:0] fp_q = 10'h000;
  logic [7:0] rd;
  logic [7:0] rdata;
  logic narrow, path, fast, fclr, rx_bit, rx_valid, in_ready, stall, sstart;
  logic [1:0] fidx;
  int bad_count = 0;
  int check_count = 0;
  int sent = 0;
  int rcvd = 0;
  int n = 0;
  int frises = 0;
  int pulses = 0;
  int supers = 0;
  always #20 clk_i = ~clk_i;
  gdcj_link_if link_if ();
  gdcj_mapper_shaper gdcj_mapper_shaper_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_if.mapper), .in_valid_i(in_valid), .in_bit_i(in_bit),
    .in_ready_o(in_ready), .stall_o(stall), .super_start_o(sstart),
    .frame_idx_o(fidx), .frame_pulses_o(fpulses));
  gdcj_line_channel gdcj_line_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_if.line), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .host_mode_i(host), .hw_bw_low_i(hw_low), .hw_bw_high_i(hw_high),
    .hw_path_tx_i(hw_path), .narrow_bw_o(narrow), .path_tx_o(path),
    .fast_recovery_o(fast), .fifo_clear_o(fclr), .rx_bit_o(rx_bit),
    .rx_valid_o(rx_valid));
  gdcj_assertions gdcj_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .tclk(link_if.tclk), .tdata(link_if.tdata));
  function automatic logic pat(int k);
    return k[0] ^ k[2] ^ k[5];
  endfunction
  task automatic check(string nm, logic [11:0] exp, logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic reg_rd(logic [7:0] a);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_i);
    rd = rdata;
    rd_s = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic idle(int c);
    repeat (c) @(negedge clk_i);
  endtask
  always @(negedge clk_i) begin
    in_valid <= feed;
    in_bit <= pat(sent);
  end
  always @(posedge clk_i) begin
    if (in_valid && !in_ready)
      refused = 1'b1;
    if (in_valid && in_ready)
      sent++;
    if (rx_valid) begin
      check("rx_bit", 12'(pat(rcvd)), 12'(rx_bit));
      rcvd++;
    end
    if (link_if.tclk && !tq)
      frises++;
    if (link_if.tclk && !tq)
      pulses++;
    // index looked at late so the last pulse's rise is counted first
    if (!rst_i && idx_q != idx_qq) begin
      check("frame", (idx_qq == 2'h2) ? 12'h26E : 12'h26D, 12'(frises));
      frises = 0;
    end
    if (!rst_i && fpulses == 10'h000 && fp_q != 10'h000)
      check("fpulses", (idx_q == 2'h2) ? 12'h26E : 12'h26D, 12'(fp_q));
    if (sstart && supers > 0)
      check("super", 12'h748, 12'(pulses));
    if (sstart)
      pulses = 0;
    if (sstart)
      supers++;
    if (rst_i) begin
      frises = 0;
      pulses = 0;
      supers = 0;
    end
    tq = link_if.tclk;
    idx_qq = idx_q;
    idx_q = fidx;
    fp_q = fpulses;
  end
  initial begin
    idle(16);
    rst_i = 1'b0;
    idle(2);
    check("fast_rst", 12'h001, 12'(fast));
    reg_rd(OFF_ATT_CTRL_CH0);
    check("ch0_rst", 12'h000, 12'(rd));
    reg_rd(OFF_ATT_CTRL_CH2);
    check("ch2_rst", 12'h000, 12'(rd));
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr);
      check("rdata", 12'(rows[i].rdata), 12'(rd));
      check("ctrl", 12'(rows[i].outs), 12'({narrow, path, fast}));
    end
    feed = 1'b1;
    for (int k = 0; k < 30000 && supers < 3; k++)
      @(negedge clk_i);
    if (supers < 3) begin
      bad_count++;
      stop_test();
    end
    check("refused", 12'h001, 12'(refused));
    feed = 1'b0;
    idle(200);
    check("stall", 12'h001, 12'(stall));
    check("drained", 12'(sent), 12'(rcvd));
    reg_wr(OFF_ATT_CTRL_CH0, 8'h08);
    n = rcvd;
    feed = 1'b1;
    idle(100);
    feed = 1'b0;
    idle(100);
    check("fifo_clr", 12'h001, 12'(fclr));
    check("dropped", 12'(n), 12'(rcvd));
    // silence longer than 59 slots, then data must still come through
    reg_wr(OFF_ATT_CTRL_CH0, 8'h00);
    idle(240);
    rcvd = sent;
    feed = 1'b1;
    idle(40);
    feed = 1'b0;
    idle(100);
    check("gap_rx", 12'(sent), 12'(rcvd));
    // second reset under pin control: recovery cannot be turned off
    rst_i = 1'b1;
    host = 1'b0;
    hw_low = 1'b1;
    hw_path = 1'b1;
    idle(16);
    rst_i = 1'b0;
    idle(4);
    reg_wr(OFF_ATT_CTRL_CH0, 8'h10);
    reg_rd(OFF_ATT_CTRL_CH0);
    check("pin_rd", 12'h010, 12'(rd));
    check("pin_ctrl", 12'h007, 12'({narrow, path, fast}));
    stop_test();
  end
endmodule
`default_nettype wire
